// file: rtl/prom_serial_loader.v
// parallel prom to serial configuration stream loader
// Function
// - slave mode older target: loader waits after clear rises before output.
// - loader makes prom addresses, serialises bytes, watches status lines.
// - address advances as the seventh bit of each byte ends, while the last bit shifts out.
// - clear line low during configuration resets loader; await target reset.
// - completion high: release prom select, float serial data output.
// - master mode: loader runs from target supplied configuration clock.
// - slave mode: one oscillator clocks loader and target.
// - prom address width is a parameter, default 19 lines.
// - slave delay counter starts at clear rise, configurable, e.g. 40.
// - cascaded proms get active-low enables decoded from extra msbs.
`timescale 1ns/1ps
`include "cfg_loader_regs.vh"
module prom_serial_loader #(
  parameter ADDR_WIDTH    = `ADDR_WIDTH_DEF,
  parameter CHIP_SEL_BITS = `CHIP_SEL_BITS_DEF,
  parameter SLAVE_WAIT    = `SLAVE_WAIT_DEF,
  parameter MSB_FIRST     = `MSB_FIRST_DEF
) (
  // clock and reset
  input  wire                          SYS_CLK_IN,
  input  wire                          RST_B_IN,
  // mode: slave with older target needs start delay
  input  wire                          SLAVE_DELAY_EN_IN,
  // target status lines
  input  wire                          CFG_CLEAR_B_IN,
  input  wire                          CFG_DONE_IN,
  input  wire                          CONFIG_SERIAL_CLOCK_IN,
  // prom side
  input  wire [`BYTE_BITS-1:0]         PROM_DATA_IN,
  output reg  [ADDR_WIDTH-1:0]         PROM_ADDR_OUT,
  output reg                           PROM_CS_B_OUT,
  output reg  [(1<<CHIP_SEL_BITS)-1:0] PROM_CE_B_OUT,
  // serial data to target
  output reg                           SER_DATA_OUT,
  output reg                           SER_DATA_OE_OUT
);
  localparam SB = (CHIP_SEL_BITS > 0) ? CHIP_SEL_BITS : 1;
  localparam TOT = ADDR_WIDTH + CHIP_SEL_BITS;
  localparam [`BIT_CNT_WIDTH-1:0] LAST_SHIFT =
    {{(`BIT_CNT_WIDTH-1){1'b1}}, 1'b0};

  reg [1:0] clr_sync_q;
  reg [1:0] done_sync_q;
  reg [1:0] config_serial_clock_sync_q;
  reg       config_serial_clock_last_q;
  reg [1:0] dly_sync_q;
  wire      clr_s  = clr_sync_q[1];
  wire      dly_s  = dly_sync_q[1];
  wire      done_s = done_sync_q[1];
  // falling edge of configuration clock: target samples on rising
  wire      config_serial_clock_fall = config_serial_clock_last_q & ~config_serial_clock_sync_q[1];

  reg [2:0]                   state_q;
  reg [TOT-1:0]               addr_q;
  reg [`BYTE_BITS-1:0]        shreg_q;
  reg [`BYTE_BITS-1:0]        data_meta_q;
  reg [`BYTE_BITS-1:0]        data_sync_q;
  reg [`BIT_CNT_WIDTH-1:0]    bit_q;
  reg [`WAIT_CNT_WIDTH-1:0]   wait_q;
  wire [SB-1:0]               sel_bits;
  wire [(1<<SB)-1:0]          ce_b;
  wire                        active = (state_q == `ST_FETCH) ||
                                       (state_q == `ST_SHIFT);

  function [0:0] next_bit;
    input [`BYTE_BITS-1:0] b;
    begin
      next_bit = MSB_FIRST ? b[`BYTE_BITS-1] : b[0];
    end
  endfunction

  generate
    if (CHIP_SEL_BITS > 0)
    begin : g_sel
      assign sel_bits = addr_q[TOT-1:ADDR_WIDTH];
    end
    else
    begin : g_nosel
      assign sel_bits = 1'b0;
    end
  endgenerate

  chip_enable_decode #(
    .SEL_BITS (SB)
  ) u_dec (
    .sel_in    (sel_bits),
    .enable_in (active),
    .ce_b_out  (ce_b)
  );

  always @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      clr_sync_q  <= 2'h0;
      done_sync_q <= 2'h0;
      config_serial_clock_sync_q <= 2'h0;
      config_serial_clock_last_q <= 1'b0;
      dly_sync_q  <= 2'h0;
      data_meta_q <= {`BYTE_BITS{1'b0}};
      data_sync_q <= {`BYTE_BITS{1'b0}};
    end
    else
    begin
      clr_sync_q  <= {clr_sync_q[0], CFG_CLEAR_B_IN};
      done_sync_q <= {done_sync_q[0], CFG_DONE_IN};
      config_serial_clock_sync_q <= {config_serial_clock_sync_q[0], CONFIG_SERIAL_CLOCK_IN};
      config_serial_clock_last_q <= config_serial_clock_sync_q[1];
      dly_sync_q  <= {dly_sync_q[0], SLAVE_DELAY_EN_IN};
      data_meta_q <= PROM_DATA_IN;
      data_sync_q <= data_meta_q;
    end
  end

  always @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= `ST_WAIT_CLEAR;
      addr_q  <= {TOT{1'b0}};
      shreg_q <= {`BYTE_BITS{1'b0}};
      bit_q   <= {`BIT_CNT_WIDTH{1'b0}};
      wait_q  <= {`WAIT_CNT_WIDTH{1'b0}};
    end
    else if (done_s)
    begin
      state_q <= `ST_FINISHED;
    end
    else if (!clr_s && state_q != `ST_WAIT_CLEAR)
    begin
      // error: restart and await target reset
      state_q <= `ST_WAIT_CLEAR;
      addr_q  <= {TOT{1'b0}};
      bit_q   <= {`BIT_CNT_WIDTH{1'b0}};
      wait_q  <= {`WAIT_CNT_WIDTH{1'b0}};
    end
    else
    begin
      case (state_q)
        `ST_WAIT_CLEAR:
        begin
          addr_q <= {TOT{1'b0}};
          wait_q <= {`WAIT_CNT_WIDTH{1'b0}};
          if (clr_s)
            state_q <= dly_s ? `ST_TIMEOUT : `ST_FETCH;
        end
        `ST_TIMEOUT:
        begin
          if (config_serial_clock_fall)
            wait_q <= wait_q + 1'b1;
          // hold outputs off until delay ends
          if (wait_q >= SLAVE_WAIT[`WAIT_CNT_WIDTH-1:0])
          begin
            wait_q  <= {`WAIT_CNT_WIDTH{1'b0}};
            state_q <= `ST_FETCH;
          end
        end
        `ST_FETCH:
        begin
          // select and address settle through prom and sync first
          if (wait_q != `FETCH_SETTLE)
            wait_q <= wait_q + 1'b1;
          else if (config_serial_clock_fall)
          begin
            shreg_q <= data_sync_q;
            bit_q   <= {`BIT_CNT_WIDTH{1'b0}};
            state_q <= `ST_SHIFT;
          end
        end
        `ST_SHIFT:
        begin
          if (config_serial_clock_fall)
          begin
            shreg_q <= MSB_FIRST ? {shreg_q[`BYTE_BITS-2:0], 1'b0}
                                 : {1'b0, shreg_q[`BYTE_BITS-1:1]};
            bit_q   <= bit_q + 1'b1;
            // seventh bit driven, byte held in shreg_q: next address
            if (bit_q == LAST_SHIFT)
              addr_q <= addr_q + 1'b1;
            // next byte loads as the last bit ends
            if (bit_q == {`BIT_CNT_WIDTH{1'b1}})
            begin
              shreg_q <= data_sync_q;
              bit_q   <= {`BIT_CNT_WIDTH{1'b0}};
            end
          end
        end
        `ST_FINISHED:
          state_q <= `ST_FINISHED;
        default:
          state_q <= `ST_WAIT_CLEAR;
      endcase
    end
  end

  always @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      PROM_ADDR_OUT   <= {ADDR_WIDTH{1'b0}};
      PROM_CS_B_OUT   <= 1'b1;
      PROM_CE_B_OUT   <= {(1<<CHIP_SEL_BITS){1'b1}};
      SER_DATA_OUT    <= 1'b1;
      SER_DATA_OE_OUT <= 1'b0;
    end
    else
    begin
      PROM_ADDR_OUT   <= addr_q[ADDR_WIDTH-1:0];
      // select released and output floated when not active
      PROM_CS_B_OUT   <= ~active;
      PROM_CE_B_OUT   <= ce_b[(1<<CHIP_SEL_BITS)-1:0];
      SER_DATA_OUT    <= (state_q == `ST_SHIFT) ? next_bit(shreg_q) : 1'b1;
      SER_DATA_OE_OUT <= (state_q == `ST_SHIFT);
    end
  end
endmodule // prom_serial_loader

// file: rtl/cfg_loader_regs.vh
// constants for the parallel prom serial configuration loader
`ifndef CFG_LOADER_REGS_VH
`define CFG_LOADER_REGS_VH
`define ADDR_WIDTH_DEF     19
`define CHIP_SEL_BITS_DEF  0
`define SLAVE_WAIT_DEF     40
`define WAIT_CNT_WIDTH     16
`define FETCH_SETTLE       16'h0004
`define BYTE_BITS          8
`define BIT_CNT_WIDTH      3
`define MSB_FIRST_DEF      1
`define ST_WAIT_CLEAR      3'h0
`define ST_TIMEOUT         3'h1
`define ST_FETCH           3'h2
`define ST_SHIFT           3'h3
`define ST_FINISHED        3'h4
`endif

// file: rtl/chip_enable_decode.v
// binary decode of the upper address bits into active-low prom enables
`timescale 1ns/1ps
module chip_enable_decode #(
  parameter SEL_BITS = 1
) (
  // select field
  input  wire [SEL_BITS-1:0]      sel_in,
  input  wire                     enable_in,
  // active-low enables
  output wire [(1<<SEL_BITS)-1:0] ce_b_out
);
  genvar i;
  generate
    for (i = 0; i < (1 << SEL_BITS); i = i + 1)
    begin : g_ce
      assign ce_b_out[i] = ~(enable_in && (sel_in == i));
    end
  endgenerate
endmodule // chip_enable_decode

// file: sim/loader_props.sv
// assertions on the loader ports
`timescale 1ns/1ps
module loader_props #(
  parameter ADDR_WIDTH    = 19,
  parameter CHIP_SEL_BITS = 0
) (
  input wire                          SYS_CLK_IN,
  input wire                          RST_B_IN,
  input wire                          SLAVE_DELAY_EN_IN,
  input wire                          CFG_CLEAR_B_IN,
  input wire                          CFG_DONE_IN,
  input wire                          CONFIG_SERIAL_CLOCK_IN,
  input wire [7:0]                    PROM_DATA_IN,
  input wire [ADDR_WIDTH-1:0]         PROM_ADDR_OUT,
  input wire                          PROM_CS_B_OUT,
  input wire [(1<<CHIP_SEL_BITS)-1:0] PROM_CE_B_OUT,
  input wire                          SER_DATA_OUT,
  input wire                          SER_DATA_OE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  property p_rst_idle; $rose(RST_B_IN) |->
    PROM_ADDR_OUT == 0 && PROM_CS_B_OUT && !SER_DATA_OE_OUT; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle");
  property p_done_off; $rose(CFG_DONE_IN) |->
    ##[1:4] PROM_CS_B_OUT && !SER_DATA_OE_OUT; endproperty
  a_done_off: assert property (p_done_off) else $error("no release");
  property p_done_hold; CFG_DONE_IN [*5] |->
    PROM_CS_B_OUT && !SER_DATA_OE_OUT; endproperty
  a_done_hold: assert property (p_done_hold) else $error("drive");
  property p_err; (!CFG_CLEAR_B_IN && !CFG_DONE_IN) [*6] |->
    PROM_ADDR_OUT == 0 && PROM_CS_B_OUT; endproperty
  a_err: assert property (p_err) else $error("no restart");
  property p_step; $changed(PROM_ADDR_OUT) |-> PROM_ADDR_OUT == 0 ||
    PROM_ADDR_OUT == $past(PROM_ADDR_OUT) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("addr jump");
  property p_hold; $changed(PROM_ADDR_OUT) && CFG_CLEAR_B_IN |=>
    ($stable(PROM_ADDR_OUT) || !CFG_CLEAR_B_IN) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("addr early");
  property p_oe_cs; SER_DATA_OE_OUT |-> !PROM_CS_B_OUT; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("oe without cs");
  property p_wait; $rose(CFG_CLEAR_B_IN) && SLAVE_DELAY_EN_IN |=>
    PROM_CS_B_OUT [*8]; endproperty
  a_wait: assert property (p_wait) else $error("no wait");
  property p_go; $rose(CFG_CLEAR_B_IN) && !SLAVE_DELAY_EN_IN &&
    !CFG_DONE_IN |-> ##[2:5] !PROM_CS_B_OUT; endproperty
  a_go: assert property (p_go) else $error("late start");
  property p_ce; (&PROM_CE_B_OUT) == PROM_CS_B_OUT; endproperty
  a_ce: assert property (p_ce) else $error("enable mismatch");
  property p_float; !SER_DATA_OE_OUT |-> SER_DATA_OUT; endproperty
  a_float: assert property (p_float) else $error("idle data");
endmodule // loader_props
bind prom_serial_loader loader_props #(.ADDR_WIDTH(ADDR_WIDTH),
  .CHIP_SEL_BITS(CHIP_SEL_BITS)) i_loader_props (.SYS_CLK_IN(SYS_CLK_IN),
  .RST_B_IN(RST_B_IN), .SLAVE_DELAY_EN_IN(SLAVE_DELAY_EN_IN),
  .CFG_CLEAR_B_IN(CFG_CLEAR_B_IN), .CFG_DONE_IN(CFG_DONE_IN),
  .CONFIG_SERIAL_CLOCK_IN(CONFIG_SERIAL_CLOCK_IN),
  .PROM_DATA_IN(PROM_DATA_IN), .PROM_ADDR_OUT(PROM_ADDR_OUT),
  .PROM_CS_B_OUT(PROM_CS_B_OUT), .PROM_CE_B_OUT(PROM_CE_B_OUT),
  .SER_DATA_OUT(SER_DATA_OUT), .SER_DATA_OE_OUT(SER_DATA_OE_OUT));

// file: sim/cfg_target_model.sv
// target serial port and parallel prom model
`timescale 1ns/1ps
module cfg_target_model (
  input  wire        run_in,
  input  wire [18:0] addr_in,
  input  wire        cs_b_in,
  input  wire        sdata_in,
  input  wire        soe_in,
  output reg         config_serial_clock_out,
  output wire [7:0]  data_out
);
  reg [7:0] shift_q = 8'h00;
  integer   bits_q = 0;
  integer   falls_q = 0;
  // 5 MHz, long low phase, still outside frames
  // clock only while the target is ready
  initial
  begin
    config_serial_clock_out = 1'b0;
    #7;
    forever
    begin
      #150 config_serial_clock_out = run_in;
      #50 config_serial_clock_out = 1'b0;
    end
  end
  // prom byte, inverted pattern when deselected
  assign data_out = {8{cs_b_in}} ^ addr_in[7:0] ^ 8'h3c;
  always @(negedge config_serial_clock_out) falls_q <= falls_q + 1;
  // target takes data on the rising clock
  always @(posedge config_serial_clock_out)
    if (soe_in)
    begin
      shift_q <= {shift_q[6:0], sdata_in};
      bits_q <= bits_q + 1;
    end
endmodule // cfg_target_model

// file: sim/tb_top.sv
// self-checking bench for the prom serial loader
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         dly_en = 1'b0;
  reg         clr_b = 1'b0;
  reg         done = 1'b0;
  reg         run = 1'b0;
  wire        config_serial_clock;
  wire [7:0]  pdata;
  wire [18:0] addr;
  wire        cs_b;
  wire [0:0]  ce_b;
  wire        sdo;
  wire        soe;
  integer     fail_count = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  always #12.5 clk = ~clk;
  prom_serial_loader #(.SLAVE_WAIT(4)) i_prom_serial_loader (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .SLAVE_DELAY_EN_IN(dly_en),
    .CFG_CLEAR_B_IN(clr_b), .CFG_DONE_IN(done),
    .CONFIG_SERIAL_CLOCK_IN(config_serial_clock), .PROM_DATA_IN(pdata),
    .PROM_ADDR_OUT(addr), .PROM_CS_B_OUT(cs_b), .PROM_CE_B_OUT(ce_b),
    .SER_DATA_OUT(sdo), .SER_DATA_OE_OUT(soe));
  cfg_target_model i_cfg_target_model (.run_in(run), .addr_in(addr),
    .cs_b_in(cs_b), .sdata_in(sdo), .soe_in(soe), .config_serial_clock_out(config_serial_clock),
    .data_out(pdata));
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (e !== g)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count = fail_count + 1;
    end
  end
  endtask
  task rst;
  begin
    rst_b <= 1'b0;
    clr_b <= 1'b0;
    done <= 1'b0;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
  end
  endtask
  task start(input d);
    integer f;
    integer n;
  begin
    f = i_cfg_target_model.falls_q;
    n = 0;
    dly_en <= d;
    clr_b <= 1'b1;
    run <= 1'b1;
    while (soe !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk("lead falls", d, i_cfg_target_model.falls_q - f > 4);
    chk("first addr", 0, addr);
    chk("ce_b run", 0, ce_b);
  end
  endtask
  task bytes(input integer cnt);
    integer b;
    integer k;
    integer n;
  begin
    b = i_cfg_target_model.bits_q;
    for (k = 0; k < cnt; k = k + 1)
    begin
      n = 0;
      while (i_cfg_target_model.bits_q < b + 8 * k + 8 && n < 200)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk("byte", k[7:0] ^ 8'h3c, i_cfg_target_model.shift_q);
    end
  end
  endtask
  task t_done;
    integer b;
  begin
    rst;
    start(1'b0);
    bytes(3);
    done <= 1'b1;
    repeat (6) @(posedge clk);
    chk("cs_b done", 1, cs_b);
    chk("oe done", 0, soe);
    chk("ce_b done", 1, ce_b);
    b = i_cfg_target_model.bits_q;
    repeat (40) @(posedge clk);
    chk("bits frozen", b, i_cfg_target_model.bits_q);
  end
  endtask
  task t_abort;
  begin
    rst;
    start(1'b0);
    bytes(2);
    clr_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk("addr err", 0, addr);
    chk("oe err", 0, soe);
    start(1'b0);
    bytes(2);
  end
  endtask
  task t_delay;
  begin
    rst;
    start(1'b1);
    bytes(2);
  end
  endtask
  task results;
  begin
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  initial
  begin
    t_done;
    t_abort;
    t_delay;
    results;
  end
endmodule // tb_top
